// >>> sync_burst_sram_control_port.sv
// pipelined burst memory with synchronous control port and storage
// How it works
// - address bits, burst bits included, are taken on accepted load edges with the device selected.
// - a load writes a lane only when its select and the strobe are both low; a write burst's advance needs only the select low.
// - select a..d governs data lane a..d together with its parity bit.
// - the write strobe is sampled only on edges with clock qualify low.
// - advance high in an accepted cycle of a live burst steps the burst counter.
// - advance low in an accepted, selected cycle loads the presented address.
// - every input but reset and the order strap is taken on the rising edge and ignored when qualify high.
// - the first chip select is active low.
// - the second chip select is active high.
// - the third chip select is active low; all three select the device.
// - qualify high freezes all state but the order strap latch instead of deselecting.
// - data drivers are off on write data, after deselect, and deselected.
// - order strap high gives interleaved order, low gives linear order.
`timescale 1ns/10ps
`include "sram_port_params.svh"
module sync_burst_sram_control_port
  import sram_port_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W,
  parameter int LANES = `LANES,
  parameter int LANE_W = `LANE_W
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic clock_qualify_n_i,
  input wire logic [ADDR_W-1:2] addr_upper_i,
  input wire logic burst_addr_bit_one_i,
  input wire logic burst_addr_bit_zero_i,
  input wire logic lane_a_write_sel_n_i,
  input wire logic lane_b_write_sel_n_i,
  input wire logic lane_c_write_sel_n_i,
  input wire logic lane_d_write_sel_n_i,
  input wire logic write_strobe_n_i,
  input wire logic advance_or_load_i,
  input wire logic chip_select_first_n_i,
  input wire logic chip_select_second_i,
  input wire logic chip_select_third_n_i,
  input wire logic output_enable_n_i,
  input wire logic burst_order_i,
  input wire logic [LANES*LANE_W-1:0] data_i,
  output logic [LANES*LANE_W-1:0] data_o,
  output logic [LANES*LANE_W-1:0] data_oe_o
);
  localparam int WORDS = 1 << ADDR_W;
  wire [LANES*LANE_W-1:0] nxt_rd_data;
  logic accept;
  logic selected;
  logic [LANES-1:0] sel_n;
  logic [ADDR_W-1:0] burst_addr_ff;
  logic [1:0] burst_start_ff;
  logic [1:0] burst_cnt_ff;
  logic [1:0] nxt_cnt;
  logic [1:0] nxt_low;
  logic [ADDR_W-1:0] nxt_addr;
  logic active_ff;
  logic write_cmd_ff;
  logic order_ff;
  logic order_seen_ff;
  cmd_t cmd_ff;
  cmd_t nxt_cmd;
  phase_t phase_ff;
  phase_t data_phase_ff;
  logic [LANES*LANE_W-1:0] data_ff;
  logic [LANES*LANE_W-1:0] oe_ff;

  // qualify low lets an edge count; high stretches the previous cycle
  assign accept = ~clock_qualify_n_i;
  assign selected = ~chip_select_first_n_i & chip_select_second_i
                    & ~chip_select_third_n_i;
  assign sel_n = {lane_d_write_sel_n_i, lane_c_write_sel_n_i,
                  lane_b_write_sel_n_i, lane_a_write_sel_n_i};

  // strap caught once after reset release; must not move in operation
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      order_ff <= `BURST_INTERLEAVED;
      order_seen_ff <= 1'b0;
    end else if (!order_seen_ff) begin
      order_ff <= burst_order_i;
      order_seen_ff <= 1'b1;
    end
  end

  always_comb begin
    nxt_cnt = burst_cnt_ff + 2'h1;
    if (order_ff) begin
      nxt_low = burst_start_ff ^ nxt_cnt;
    end else begin
      nxt_low = burst_start_ff + nxt_cnt;
    end
    nxt_addr = {burst_addr_ff[ADDR_W-1:2], nxt_low};
  end

  always_comb begin
    nxt_cmd = '0;
    if (advance_or_load_i) begin
      nxt_cmd.addr = nxt_addr;
      nxt_cmd.write = write_cmd_ff;
    end else begin
      nxt_cmd.addr = {addr_upper_i, burst_addr_bit_one_i,
                      burst_addr_bit_zero_i};
      nxt_cmd.write = ~write_strobe_n_i;
    end
    // strobe high on a load, or a read burst on an advance, masks every lane select
    nxt_cmd.lane_wr = nxt_cmd.write ? ~sel_n : '0;
  end

  // a bare advance after deselect is undefined; we keep it deselected
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      burst_addr_ff <= `RESET_ADDR;
      burst_start_ff <= 2'h0;
      burst_cnt_ff <= 2'h0;
      active_ff <= 1'b0;
      write_cmd_ff <= 1'b0;
      cmd_ff <= '0;
      phase_ff <= ST_IDLE;
    end else if (accept) begin
      if (!advance_or_load_i) begin
        active_ff <= selected;
        if (selected) begin
          burst_addr_ff <= nxt_cmd.addr;
          burst_start_ff <= nxt_cmd.addr[1:0];
          burst_cnt_ff <= 2'h0;
          write_cmd_ff <= nxt_cmd.write;
        end
      end else if (active_ff) begin
        burst_addr_ff <= nxt_addr;
        burst_cnt_ff <= nxt_cnt;
      end
      cmd_ff <= nxt_cmd;
      if ((advance_or_load_i ? active_ff : selected)) begin
        phase_ff <= nxt_cmd.write ? ST_WRITE : ST_READ;
      end else begin
        phase_ff <= ST_IDLE;
      end
    end
  end

  // write data follows its command by one cycle, as on a pipelined part
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_phase_ff <= ST_IDLE;
    end else if (accept) begin
      data_phase_ff <= phase_ff;
    end
  end

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    // one array per lane keeps each write process the only driver
    logic [LANE_W-1:0] lane_mem [WORDS];
    always_ff @(posedge sys_clk_i) begin
      if (accept && phase_ff == ST_WRITE && cmd_ff.lane_wr[g]) begin
        lane_mem[cmd_ff.addr] <= data_i[g*LANE_W +: LANE_W];
      end
    end
    assign nxt_rd_data[g*LANE_W +: LANE_W] = lane_mem[cmd_ff.addr];
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      data_ff <= '0;
      oe_ff <= '0;
    end else if (accept) begin
      data_ff <= nxt_rd_data;
      // drive only for a read data phase that follows a live cycle
      if (phase_ff == ST_READ && data_phase_ff != ST_IDLE
          && !output_enable_n_i) begin
        oe_ff <= '1;
      end else begin
        oe_ff <= '0;
      end
    end
  end

  assign data_o = data_ff;
  assign data_oe_o = oe_ff;

  // read issued after a live cycle, with output enable low
  sequence read_live_s;
    accept && phase_ff == ST_READ && data_phase_ff != ST_IDLE
      && !output_enable_n_i;
  endsequence

  off_in_write_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && phase_ff == ST_WRITE |=> data_oe_o == '0)
    else $error("drivers on during write data");
  off_after_idle_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && data_phase_ff == ST_IDLE |=> data_oe_o == '0)
    else $error("drivers on after deselect");
  read_drive_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    read_live_s |=> data_oe_o == '1)
    else $error("read data not driven");
  freeze_all_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    !accept |=> $stable(burst_addr_ff) && $stable(phase_ff)
      && $stable(data_oe_o))
    else $error("state moved while unqualified");
  load_addr_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && !advance_or_load_i && selected |=>
      burst_addr_ff == {$past(addr_upper_i), $past(burst_addr_bit_one_i),
      $past(burst_addr_bit_zero_i)})
    else $error("load address not taken");
  upper_fixed_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && advance_or_load_i |=>
      burst_addr_ff[ADDR_W-1:2] == $past(burst_addr_ff[ADDR_W-1:2]))
    else $error("upper address moved in burst");
  step_addr_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && advance_or_load_i && active_ff |=>
      burst_cnt_ff == $past(burst_cnt_ff) + 2'h1)
    else $error("burst counter did not step");
  no_write_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && !advance_or_load_i && write_strobe_n_i
      |=> cmd_ff.lane_wr == '0)
    else $error("lane write without strobe");
  lane_map_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && !advance_or_load_i && !write_strobe_n_i
      |=> cmd_ff.lane_wr == ~$past(sel_n))
    else $error("lane select mapped wrongly");
  deselect_a: assert property (
    @(posedge sys_clk_i) disable iff (reset_i)
    accept && !advance_or_load_i && !selected |=> phase_ff == ST_IDLE)
    else $error("selected without all chip selects");
endmodule

// >>> sram_port_params.svh
// constants for the synchronous burst memory control port
`ifndef SRAM_PORT_PARAMS_SVH
`define SRAM_PORT_PARAMS_SVH
`define ADDR_W 12
`define LANES 4
`define LANE_W 9
`define RESET_ADDR 12'h000
`define BURST_INTERLEAVED 1'b1
`endif

// >>> sram_port_pkg.sv
// types for the synchronous burst memory control port
`include "sram_port_params.svh"
package sram_port_pkg;
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`LANES-1:0] lane_wr;
    logic write;
  } cmd_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_READ = 3'b010,
    ST_WRITE = 3'b100
  } phase_t;
endpackage

// >>> mem_host_model.sv
// controller model that drives strobe, lanes and the write data bus
`timescale 1ns/10ps
module mem_host_model
  import sram_port_pkg::*;
(
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic adv_i,
  input wire logic [2:0] cs_i,
  input wire cmd_t cmd_i,
  input wire logic [35:0] wdata_i,
  output logic qual_n_o,
  output logic strobe_n_o,
  output logic [3:0] lane_n_o,
  output logic [35:0] bus_o
);
  logic wr_ff;
  logic burst_wr_ff;
  logic [35:0] buf_ff;
  assign qual_n_o = hold_i;
  assign strobe_n_o = ~cmd_i.write;
  assign lane_n_o = ~cmd_i.lane_wr;
  always_ff @(posedge clk_i) begin
    if (!hold_i) begin
      if (!adv_i) begin
        wr_ff <= cmd_i.write && cs_i == 3'b010;
        burst_wr_ff <= cmd_i.write && cs_i == 3'b010;
      end else begin
        // an advance keeps the direction of the burst's load
        wr_ff <= burst_wr_ff;
      end
      buf_ff <= wdata_i;
    end
  end
  // released bus shows the inverse so a stale word never passes
  assign bus_o = wr_ff ? buf_ff : ~buf_ff;
endmodule

// >>> tb_top.sv
// self-checking bench for the burst memory control port
`timescale 1ns/10ps
module tb_top;
  import sram_port_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic hold = 1'b0;
  logic adv = 1'b0;
  logic order = 1'b1;
  logic oen = 1'b0;
  logic eo = 1'b0;
  logic [2:0] cs = 3'b101;
  cmd_t cmd = '0;
  logic [35:0] wdata = '0;
  logic qual_n, strobe_n;
  logic [3:0] lane_n, wl;
  logic [35:0] bus, dout, doe, wd;
  logic [35:0] mem [4096];
  logic [31:0] seed = 32'h0000_a70c;
  logic [11:0] sa [4];
  logic [11:0] start, wa;
  logic [1:0] cnt;
  int kind [4] = '{0, 0, 0, 0};
  int errors = 0;
  int checks_done = 0;
  always #2.5 sys_clk = ~sys_clk;
  mem_host_model host (.clk_i(sys_clk), .hold_i(hold), .adv_i(adv),
    .cs_i(cs), .cmd_i(cmd), .wdata_i(wdata), .qual_n_o(qual_n),
    .strobe_n_o(strobe_n), .lane_n_o(lane_n), .bus_o(bus));
  sync_burst_sram_control_port uut (
    .sys_clk_i(sys_clk), .reset_i(reset), .clock_qualify_n_i(qual_n),
    .addr_upper_i(cmd.addr[11:2]), .burst_addr_bit_one_i(cmd.addr[1]),
    .burst_addr_bit_zero_i(cmd.addr[0]), .lane_a_write_sel_n_i(lane_n[0]),
    .lane_b_write_sel_n_i(lane_n[1]), .lane_c_write_sel_n_i(lane_n[2]),
    .lane_d_write_sel_n_i(lane_n[3]), .write_strobe_n_i(strobe_n),
    .advance_or_load_i(adv), .chip_select_first_n_i(cs[2]),
    .chip_select_second_i(cs[1]), .chip_select_third_n_i(cs[0]),
    .output_enable_n_i(oen), .burst_order_i(order), .data_i(bus),
    .data_o(dout), .data_oe_o(doe));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic cmp(string what, logic [35:0] exp, logic [35:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(logic h, logic [2:0] c, logic a, logic w,
                     logic [11:0] ad, logic [3:0] l);
    @(negedge sys_clk);
    cmp("oe", {36{kind[1] == 1 && kind[2] != 0 && !eo}}, doe);
    if (kind[1] == 1) cmp("rd", mem[sa[1]], dout);
    hold = h;
    cs = c;
    if (kind[0] == 0) a = 1'b0;
    adv = a;
    cmd = '{addr: ad, lane_wr: l, write: w};
    wdata = 36'({rnd(), rnd()});
    oen = rnd() % 8 == 0;
    @(posedge sys_clk);
    // frozen edge: every expectation stands
    if (h || reset) return;
    eo = oen;
    if (kind[0] == 2) begin
      for (int g = 0; g < 4; g++) if (wl[g]) mem[wa][g*9+:9] = wd[g*9+:9];
    end
    for (int i = 3; i > 0; i--) begin
      kind[i] = kind[i-1];
      sa[i] = sa[i-1];
    end
    if (!a) begin
      kind[0] = c != 3'b010 ? 0 : w ? 2 : 1;
      start = ad;
      cnt = 2'b00;
    end else if (kind[0] != 0) cnt++;
    sa[0] = {start[11:2], order ? start[1:0] ^ cnt : start[1:0] + cnt};
    wa = sa[0];
    wl = l;
    wd = wdata;
  endtask
  initial begin
    for (int p = 0; p < 2; p++) begin
      order = p == 0;
      reset = 1'b1;
      kind = '{0, 0, 0, 0};
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      hold = 1'b0;
      cs = 3'b101;
      adv = 1'b0;
      cmd = '0;
      reset = 1'b0;
      for (int i = 0; i < 16; i++) cyc(0, 3'b010, 0, 1, 12'hff0 + 12'(i), 4'hf);
      repeat (60) cyc(rnd() % 4 == 0, rnd() % 2 ? 3'b010 : 3'(rnd()), 0, 1,
        12'hff0 | 12'(rnd() % 16), 4'(rnd()));
      repeat (300) cyc(rnd() % 4 == 0, rnd() % 2 ? 3'b010 : 3'(rnd()),
        1'(rnd()), 0, 12'hff0 | 12'(rnd() % 16), 4'(rnd()));
    end
    report_and_stop();
  end
endmodule
